// >>> adc_readout_pkg.sv
// constants, modes and timing for the converter read-out port
// assumes a 10 MHz core clock and an eight-channel, 16-bit result bank
package adc_readout_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int RES_W = 16;
  localparam int HALF_CH = 4;
  localparam int BANK_W = 128;
  localparam int PTR_W = 4;
  localparam int SER_CNT_W = 7;
  localparam logic [6:0] SER_BITS_PER_LINE = 7'h40;
  localparam logic [6:0] SER_FIRST_END = 7'h10;
  localparam int SYNC_W = 12;
  // idle pin levels: select, strobe and power-down sit high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 12'h403;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES_RAW =
    (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [15:0] CONV_CYCLES =
    (CONV_CYCLES_RAW < 1) ? 16'h0001 : 16'(CONV_CYCLES_RAW);

  // ----------------------------------------------------------------
  // oversampling codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OS_CODE_INVALID = 3'h7;
  localparam logic [6:0] OS_RATIO_ONE = 7'h01;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'h0,
    MODE_SERIAL = 2'h1,
    MODE_BYTE = 2'h2
  } read_mode_t;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'h0,
    CONV_RUN = 2'h1,
    CONV_LATCH = 2'h2
  } conv_state_t;

endpackage

// >>> bit_sync.sv
// two-stage synchroniser for a group of independent pin levels
// assumes each bit is a slow level; words need another crossing
`timescale 1ns/1ps
`default_nettype none
module bit_sync
  import adc_readout_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] meta;

  // ----------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------
  // reset to the idle pin levels, so no false strobe edge follows reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= SYNC_IDLE;
      sync_out <= SYNC_IDLE;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> conv_sequencer.sv
// conversion start, busy timing and result latching
// assumes start inputs already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
module conv_sequencer
  import adc_readout_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_a_in,
  input wire logic start_b_in,
  input wire logic powered_in,
  input wire logic [2:0] os_code_in,
  input wire logic [BANK_W-1:0] sample_in,
  output logic busy_out,
  output logic new_results_out,
  output logic [BANK_W-1:0] results_out
);

  conv_state_t state;
  logic start_a_d;
  logic start_b_d;
  logic seen_a;
  logic seen_b;
  logic [15:0] count;
  logic [15:0] conv_len;

  // a longer filter ratio stretches the conversion
  assign conv_len = (os_code_in == OS_CODE_INVALID) ? CONV_CYCLES :
                    16'(CONV_CYCLES << os_code_in);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_a_d <= 1'b0;
      start_b_d <= 1'b0;
    end else begin
      start_a_d <= start_a_in;
      start_b_d <= start_b_in;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= CONV_IDLE;
      seen_a <= 1'b0;
      seen_b <= 1'b0;
      count <= 16'h0000;
      busy_out <= 1'b0;
      new_results_out <= 1'b0;
    end else begin
      new_results_out <= 1'b0;
      case (state)
        CONV_IDLE: begin
          if ((seen_a || (start_a_in && !start_a_d)) &&
              (seen_b || (start_b_in && !start_b_d)) && powered_in) begin
            state <= CONV_RUN;
            busy_out <= 1'b1;
            seen_a <= 1'b0;
            seen_b <= 1'b0;
            count <= conv_len;
          end else if (powered_in) begin
            if (start_a_in && !start_a_d) begin
              seen_a <= 1'b1;
            end
            if (start_b_in && !start_b_d) begin
              seen_b <= 1'b1;
            end
          end
        end
        CONV_RUN: begin
          if (count == 16'h0001) begin
            state <= CONV_LATCH;
          end else begin
            count <= count - 16'h0001;
          end
        end
        CONV_LATCH: begin
          state <= CONV_IDLE;
          busy_out <= 1'b0;
          new_results_out <= 1'b1;
        end
        default: begin
          state <= CONV_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result bank
  // ----------------------------------------------------------------
  // reset clears results
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      results_out <= '0;
    end else if (state == CONV_LATCH) begin
      results_out <= sample_in;
    end
  end

endmodule
`default_nettype wire

// >>> adc_readout_port.sv
// read-out and control port of an eight-channel sampling converter
// assumes the host keeps its own timing duties; serial clock is a
// second domain that runs only inside frames
//
// How it works
// - three select pins pick the filter ratio, top pin most significant
// - busy rises only after both conversion-start groups have risen
// - start inputs are ignored while busy is high
// - busy stays high until all results are latched, then falls
// - first-channel flag floats with select high, drives once it falls
// - parallel: flag high on channel 1 strobe, low on later strobes
// - byte mode: flag high for both channel 1 bytes, low afterwards
// - serial: flag rises at select fall, drops at 16th clock fall
// - family select 0 parallel; else 0 serial, 1 byte
// - parallel drives all sixteen bits only while select and strobe low
// - byte order select high gives high byte first, low gives low
// - byte mode sends each result as two bytes on low eight pins
// - byte mode keeps bus bit 8 floating always
// - first serial line carries channels 1-4, second channels 5-8
// - power-down low: range 1 gives standby, range 0 gives shutdown
// - select rising edge floats every data output
// - serial accesses are timed against the external serial clock
// - each parallel read presents the next channel, unused channels included
// - reset during a read clears every output data register
`timescale 1ns/1ps
`default_nettype none
module adc_readout_port
  import adc_readout_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic conv_start_group_a_in,
  input wire logic conv_start_group_b_in,
  input wire logic [2:0] oversample_ratio_sel_in,
  input wire logic iface_family_sel_in,
  input wire logic serial_or_byte_sel_in,
  input wire logic byte_order_sel_in,
  input wire logic power_down_n_in,
  input wire logic range_in,
  input wire logic [BANK_W-1:0] channel_sample_in,
  output logic busy_out,
  output logic first_channel_flag_out,
  output logic first_channel_flag_oe_out,
  output logic [RES_W-1:0] data_bus_out,
  output logic [RES_W-1:0] data_bus_oe_out,
  output logic first_group_serial_out,
  output logic second_group_serial_out,
  output logic serial_oe_out,
  output logic [6:0] oversample_factor_out,
  output logic standby_out,
  output logic shutdown_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic cs_n_s;
  logic rd_n_s;
  logic start_a_s;
  logic start_b_s;
  logic [2:0] os_s;
  logic family_s;
  logic serial_or_byte_s;
  logic byte_order_s;
  logic power_down_n_s;
  logic range_s;

  bit_sync u_pin_sync (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in({range_in, power_down_n_in, byte_order_sel_in,
               serial_or_byte_sel_in, iface_family_sel_in,
               oversample_ratio_sel_in, conv_start_group_b_in,
               conv_start_group_a_in, read_strobe_n_in,
               chip_select_n_in}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign rd_n_s = pins_s[1];
  assign start_a_s = pins_s[2];
  assign start_b_s = pins_s[3];
  assign os_s = pins_s[6:4];
  assign family_s = pins_s[7];
  assign serial_or_byte_s = pins_s[8];
  assign byte_order_s = pins_s[9];
  assign power_down_n_s = pins_s[10];
  assign range_s = pins_s[11];

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  read_mode_t mode;
  logic powered;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode <= MODE_PARALLEL;
    end else if (!family_s) begin
      mode <= MODE_PARALLEL;
    end else if (serial_or_byte_s) begin
      mode <= MODE_BYTE;
    end else begin
      mode <= MODE_SERIAL;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      oversample_factor_out <= OS_RATIO_ONE;
    end else if (os_s == OS_CODE_INVALID) begin
      oversample_factor_out <= OS_RATIO_ONE;
    end else begin
      oversample_factor_out <= 7'(OS_RATIO_ONE << os_s);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_out <= 1'b0;
      shutdown_out <= 1'b0;
    end else begin
      standby_out <= !power_down_n_s && range_s;
      shutdown_out <= !power_down_n_s && !range_s;
    end
  end

  assign powered = power_down_n_s;

  // ----------------------------------------------------------------
  // conversion
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] bank;
  logic new_results;

  conv_sequencer u_conv (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_a_in(start_a_s),
    .start_b_in(start_b_s),
    .powered_in(powered),
    .os_code_in(os_s),
    .sample_in(channel_sample_in),
    .busy_out(busy_out),
    .new_results_out(new_results),
    .results_out(bank)
  );

  // ----------------------------------------------------------------
  // parallel and byte read-out
  // ----------------------------------------------------------------
  logic strobe_low;
  logic strobe_low_d;
  logic strobe_fall;
  logic [PTR_W-1:0] read_ptr;
  logic [RES_W-1:0] cur_word;
  logic take_high;
  logic par_flag;

  assign strobe_low = !cs_n_s && !rd_n_s;
  assign strobe_fall = strobe_low && !strobe_low_d;

  assign cur_word = (mode == MODE_BYTE) ?
                    bank[read_ptr[3:1]*RES_W +: RES_W] :
                    bank[read_ptr[2:0]*RES_W +: RES_W];
  assign take_high = byte_order_s ^ read_ptr[0];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_low_d <= 1'b0;
    end else begin
      strobe_low_d <= strobe_low;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_ptr <= '0;
    end else if (new_results) begin
      read_ptr <= '0;
    end else if (strobe_fall && mode != MODE_SERIAL) begin
      read_ptr <= read_ptr + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_bus_out <= 16'h0000;
    end else if (strobe_fall && mode == MODE_PARALLEL) begin
      data_bus_out <= cur_word;
    end else if (strobe_fall && mode == MODE_BYTE) begin
      data_bus_out <= {8'h00, take_high ? cur_word[15:8] : cur_word[7:0]};
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      par_flag <= 1'b0;
    end else if (strobe_fall && mode == MODE_PARALLEL) begin
      par_flag <= (read_ptr == 4'h0);
    end else if (strobe_fall && mode == MODE_BYTE) begin
      // flag on both channel 1 bytes
      par_flag <= (read_ptr < 4'h2);
    end
  end

  // drive only with select and strobe low
  // bit 8 never driven in byte mode
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_bus_oe_out <= 16'h0000;
    end else if (strobe_low && mode == MODE_PARALLEL) begin
      data_bus_oe_out <= 16'hFFFF;
    end else if (strobe_low && mode == MODE_BYTE) begin
      data_bus_oe_out <= 16'h00FF;
    end else begin
      data_bus_oe_out <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // serial read-out, serial clock domain
  // ----------------------------------------------------------------
  // the bank only changes as busy falls; the host may not clock a frame
  // across that moment, so the bank is static while this domain reads it
  logic ser_clear;
  logic [SER_CNT_W-1:0] ser_cnt;
  logic ser_first;
  logic [1:0] ser_ch;
  logic [3:0] ser_bit;

  // the select pin itself ends the frame; no clock edge is counted on
  assign ser_clear = rst_in || chip_select_n_in;
  assign ser_ch = ser_cnt[5:4];
  assign ser_bit = 4'hF - ser_cnt[3:0];

  // shifts on the external serial clock
  // one bit per clock, msb first
  always_ff @(negedge serial_clk_in or posedge ser_clear) begin
    if (ser_clear) begin
      ser_cnt <= '0;
    end else if (ser_cnt != SER_BITS_PER_LINE) begin
      ser_cnt <= ser_cnt + 7'h01;
    end
  end

  // flag up at select fall, down at 16th fall
  always_ff @(negedge serial_clk_in or posedge ser_clear) begin
    if (ser_clear) begin
      ser_first <= 1'b1;
    end else if (ser_cnt + 7'h01 == SER_FIRST_END) begin
      ser_first <= 1'b0;
    end
  end

  // first half on line a, second half on line b
  always_comb begin
    first_group_serial_out = 1'b0;
    second_group_serial_out = 1'b0;
    if (ser_cnt != SER_BITS_PER_LINE) begin
      first_group_serial_out = bank[{ser_ch, ser_bit}];
      second_group_serial_out = bank[HALF_CH*RES_W + {ser_ch, ser_bit}];
    end
  end

  // ----------------------------------------------------------------
  // output enables and first-channel flag
  // ----------------------------------------------------------------
  // serial lines float with select high
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_oe_out <= 1'b0;
    end else begin
      serial_oe_out <= !cs_n_s && mode == MODE_SERIAL;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      first_channel_flag_oe_out <= 1'b0;
    end else begin
      first_channel_flag_oe_out <= !cs_n_s;
    end
  end

  assign first_channel_flag_out = (mode == MODE_SERIAL) ? ser_first :
                                  par_flag;

endmodule
`default_nettype wire

// >>> adc_readout_monitor.sv
// concurrent checks on the converter read-out port pins
// assumes it is bound onto adc_readout_port
`timescale 1ns/1ps
`default_nettype none
module adc_readout_monitor
  import adc_readout_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic read_strobe_n_in,
  input wire logic conv_start_group_a_in,
  input wire logic conv_start_group_b_in,
  input wire logic [2:0] oversample_ratio_sel_in,
  input wire logic iface_family_sel_in,
  input wire logic serial_or_byte_sel_in,
  input wire logic power_down_n_in,
  input wire logic range_in,
  input wire logic busy_out,
  input wire logic first_channel_flag_oe_out,
  input wire logic [RES_W-1:0] data_bus_oe_out,
  input wire logic serial_oe_out,
  input wire logic [6:0] oversample_factor_out,
  input wire logic standby_out,
  input wire logic shutdown_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // pin relations
  // ------------------------------------------------------------
  a_busy_start: assert property ($rose(busy_out) |->
    $past(conv_start_group_a_in, 2) && $past(conv_start_group_b_in, 2))
    else $error("busy rose without both starts");
  a_busy_hold: assert property ($rose(busy_out) |->
    busy_out [*8]) else $error("busy pulse too short");
  a_outputs_float: assert property (chip_select_n_in [*5] |->
    !first_channel_flag_oe_out && data_bus_oe_out == 16'h0000
    && !serial_oe_out) else $error("outputs driven while deselected");
  // three synchroniser and register edges between pins and enable
  a_bus_oe_cause: assert property (|data_bus_oe_out |->
    !$past(chip_select_n_in, 3) && !$past(read_strobe_n_in, 3))
    else $error("bus driven without select and strobe");
  a_par_oe_all: assert property (
    !iface_family_sel_in && |data_bus_oe_out |->
    data_bus_oe_out == 16'hFFFF) else $error("parallel bus partly driven");
  a_byte_pins_float: assert property (
    iface_family_sel_in && serial_or_byte_sel_in |->
    data_bus_oe_out[15:8] == 8'h00) else $error("byte mode upper pins driven");
  a_serial_oe_mode: assert property (serial_oe_out |->
    iface_family_sel_in && !serial_or_byte_sel_in)
    else $error("serial lines driven outside serial mode");
  a_ratio_decode: assert property (
    $stable(oversample_ratio_sel_in) [*4] |-> oversample_factor_out ==
    ((oversample_ratio_sel_in == 3'h7) ? 7'h01 :
    7'(1 << oversample_ratio_sel_in))) else $error("ratio decode wrong");
  a_power_modes: assert property (
    ($stable(power_down_n_in) && $stable(range_in)) [*4] |->
    standby_out == (!power_down_n_in && range_in) &&
    shutdown_out == (!power_down_n_in && !range_in))
    else $error("power-down decode wrong");
endmodule
bind adc_readout_port adc_readout_monitor mon (.ref_clk_in, .rst_in,
  .chip_select_n_in, .read_strobe_n_in, .conv_start_group_a_in,
  .conv_start_group_b_in, .oversample_ratio_sel_in, .iface_family_sel_in,
  .serial_or_byte_sel_in, .power_down_n_in, .range_in, .busy_out,
  .first_channel_flag_oe_out, .data_bus_oe_out, .serial_oe_out,
  .oversample_factor_out, .standby_out, .shutdown_out);
`default_nettype wire

// >>> host_model.sv
// host controller model: select, read strobe and serial clock
// assumes the bench resolves the data pins with pull-downs
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic [15:0] bus_in,
  input wire logic flag_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic sclk_out
);
  initial begin
    cs_n_out = 1'h1;
    rd_n_out = 1'h1;
    sclk_out = 1'h0;
  end
  // ------------------------------------------------------------
  // transfers
  // ------------------------------------------------------------
  // reads kept clear of busy
  task automatic strobe(output logic [15:0] w, output logic f);
    @(negedge clk_in);
    cs_n_out = 1'h0;
    rd_n_out = 1'h0;
    repeat (5) @(negedge clk_in);
    w = bus_in;
    f = flag_in;
    rd_n_out = 1'h1;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic done;
    @(negedge clk_in);
    cs_n_out = 1'h1;
    repeat (6) @(negedge clk_in);
  endtask
  // sample on clock rise
  // clock stands low outside frames; phase kept off the core clock
  task automatic frame(output logic [63:0] a, b, output logic [16:0] f);
    @(negedge clk_in);
    cs_n_out = 1'h0;
    repeat (4) @(negedge clk_in);
    #13;
    for (int i = 0; i < 64; i++) begin
      #62.5 sclk_out = 1'h1;
      a[63 - i] = bus_in[7];
      b[63 - i] = bus_in[8];
      if (i < 17) f[16 - i] = flag_in;
      #62.5 sclk_out = 1'h0;
    end
    done();
  endtask
endmodule
`default_nettype wire

// >>> adc_readout_port_tb.sv
// self-checking bench for the converter read-out port
// assumes host_model drives select, strobe and serial clock
`timescale 1ns/1ps
`default_nettype none
module adc_readout_port_tb;
  import adc_readout_pkg::*;
  logic ref_clk = 1'h0, rst = 1'h1, start_a = 1'h0, start_b = 1'h0;
  logic fam_sel = 1'h0, sob_sel = 1'h0, order_sel = 1'h0;
  logic pd_n = 1'h1, rng = 1'h0, cs_n, rd_n, sclk, flag_w;
  logic [2:0] os_sel = 3'h0;
  logic [BANK_W-1:0] bank;
  logic busy, flag, flag_oe, ser_a, ser_b, ser_oe, power_down_n, shdn;
  logic [15:0] dbus, dbus_oe, bus;
  logic [6:0] factor;
  int num_errors = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  // pull-downs on every pin; serial lines sit on bus bits 7 and 8
  assign bus = (dbus & dbus_oe) |
    {7'h00, ser_oe & ser_b, ser_oe & ser_a, 7'h00};
  assign flag_w = flag & flag_oe;
  adc_readout_port DUT (.ref_clk_in(ref_clk), .rst_in(rst),
    .serial_clk_in(sclk), .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n),
    .conv_start_group_a_in(start_a), .conv_start_group_b_in(start_b),
    .oversample_ratio_sel_in(os_sel), .iface_family_sel_in(fam_sel),
    .serial_or_byte_sel_in(sob_sel), .byte_order_sel_in(order_sel),
    .power_down_n_in(pd_n), .range_in(rng), .channel_sample_in(bank),
    .busy_out(busy), .first_channel_flag_out(flag),
    .first_channel_flag_oe_out(flag_oe), .data_bus_out(dbus),
    .data_bus_oe_out(dbus_oe), .first_group_serial_out(ser_a),
    .second_group_serial_out(ser_b), .serial_oe_out(ser_oe),
    .oversample_factor_out(factor), .standby_out(power_down_n),
    .shutdown_out(shdn));
  host_model host (.clk_in(ref_clk), .bus_in(bus), .flag_in(flag_w),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .sclk_out(sclk));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] samp(input int i);
    return 16'h1357 * 16'(i) + 16'h8001;
  endfunction
  task automatic check(input string what, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic convert(input logic [2:0] code);
    int n, lim;
    n = 0;
    lim = int'(CONV_CYCLES) << code;
    @(negedge ref_clk);
    os_sel = code;
    start_a = 1'h1;
    repeat (8) @(negedge ref_clk);
    check("busy a only", busy, 1'h0);
    start_b = 1'h1;
    while (busy !== 1'h1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    start_a = 1'h0;
    start_b = 1'h0;
    @(negedge ref_clk);
    start_a = 1'h1;
    start_b = 1'h1;
    n = 0;
    while (busy === 1'h1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    check("busy len", n + 1 >= lim && n + 1 <= lim + 2, 1'h1);
    repeat (10) @(negedge ref_clk);
    check("busy retrigger", busy, 1'h0);
    start_a = 1'h0;
    start_b = 1'h0;
  endtask
  task automatic par_read;
    logic [15:0] w;
    logic f;
    @(negedge ref_clk);
    fam_sel = 1'h0;
    for (int i = 1; i <= 8; i++) begin
      host.strobe(w, f);
      check("par word", w, samp(i));
      check("par flag", f, i == 1);
    end
    host.done();
    check("float", {flag_oe, dbus_oe, ser_oe}, 18'h00000);
  endtask
  task automatic byte_read(input logic hi_first);
    logic [15:0] w;
    logic f;
    @(negedge ref_clk);
    fam_sel = 1'h1;
    sob_sel = 1'h1;
    order_sel = hi_first;
    for (int j = 0; j < 16; j++) begin
      host.strobe(w, f);
      check("byte", w, (samp(j / 2 + 1) >> (8 * (j[0] ^ hi_first)))
        & 16'h00FF);
      check("byte flag", f, j < 2);
    end
    host.done();
  endtask
  task automatic ser_read;
    logic [63:0] a, b;
    logic [16:0] f;
    @(negedge ref_clk);
    fam_sel = 1'h1;
    sob_sel = 1'h0;
    order_sel = 1'h0;
    repeat (4) @(negedge ref_clk);
    host.frame(a, b, f);
    check("line a", a, {samp(1), samp(2), samp(3), samp(4)});
    check("line b", b, {samp(5), samp(6), samp(7), samp(8)});
    check("ser flag", f, 17'h1FFFE);
  endtask
  task automatic reset_read;
    logic [15:0] w;
    logic f;
    @(negedge ref_clk);
    fam_sel = 1'h0;
    fork
      host.strobe(w, f);
      begin
        repeat (3) @(negedge ref_clk);
        rst = 1'h1;
        @(negedge ref_clk);
        rst = 1'h0;
      end
    join
    host.strobe(w, f);
    check("reset data", w, 16'h0000);
    host.done();
  endtask
  task automatic pins;
    for (int c = 0; c < 8; c++) begin
      @(negedge ref_clk);
      os_sel = 3'(c);
      repeat (5) @(negedge ref_clk);
      check("ratio", factor, c == 7 ? 1 : 1 << c);
    end
    for (int m = 0; m < 3; m++) begin
      @(negedge ref_clk);
      pd_n = m == 2;
      rng = m == 0;
      repeat (5) @(negedge ref_clk);
      check("power", {power_down_n, shdn}, {m == 0, m == 1});
    end
  endtask
  initial begin
    for (int i = 0; i < 8; i++) bank[16 * i +: 16] = samp(i + 1);
    repeat (3) @(negedge ref_clk);
    rst = 1'h0;
    repeat (3) @(negedge ref_clk);
    convert(3'h0);
    par_read();
    convert(3'h1);
    byte_read(1'h1);
    convert(3'h0);
    byte_read(1'h0);
    convert(3'h0);
    ser_read();
    convert(3'h0);
    reset_read();
    pins();
    summarize();
  end
  // whole run needs about a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
